// >>> asram_pkg.sv
// Shared constants and types for the asynchronous static memory host controller
package asram_pkg;
    localparam int ASRAM_CLK_PERIOD_NS   = 50;
    localparam int ASRAM_ADDR_W          = 15;
    localparam int ASRAM_DATA_W          = 8;
    // Device timing minima and maxima, in ns
    localparam int ASRAM_READ_CYCLE_NS   = 70;
    localparam int ASRAM_ADDR_ACCESS_NS  = 70;
    localparam int ASRAM_SEL_ACCESS_NS   = 70;
    localparam int ASRAM_DRIVE_ACCESS_NS = 35;
    localparam int ASRAM_OUT_OFF_NS      = 25;
    localparam int ASRAM_WRITE_CYCLE_NS  = 70;
    localparam int ASRAM_SEL_TO_END_NS   = 60;
    localparam int ASRAM_ADDR_TO_END_NS  = 60;
    localparam int ASRAM_STROBE_WIDTH_NS = 50;
    localparam int ASRAM_DATA_SETUP_NS   = 30;

    function automatic int asram_cycles(input int ns);
        int c;
        c = (ns + ASRAM_CLK_PERIOD_NS - 1) / ASRAM_CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : asram_cycles

    // Read: access measured from select and drive falling together
    localparam int ASRAM_RD_CYC = asram_cycles(ASRAM_ADDR_ACCESS_NS > ASRAM_READ_CYCLE_NS
                                               ? ASRAM_ADDR_ACCESS_NS : ASRAM_READ_CYCLE_NS);
    // Device releases the data lines this long after drive rises
    localparam int ASRAM_OFF_CYC = asram_cycles(ASRAM_OUT_OFF_NS);
    // Write strobe low: wider of the select-to-end and write cycle minima
    localparam int ASRAM_WR_CYC  = asram_cycles(ASRAM_SEL_TO_END_NS > ASRAM_WRITE_CYCLE_NS
                                               ? ASRAM_SEL_TO_END_NS : ASRAM_WRITE_CYCLE_NS);
    localparam int ASRAM_CNT_W   = 4;
    // Select-only cycle ahead of the strobe; zero setup would do, this is margin
    localparam int ASRAM_SET_CYC = 1;

    typedef enum logic [2:0] {
        ASRAM_IDLE  = 3'b000,
        ASRAM_RD    = 3'b001,
        ASRAM_RDONE = 3'b010,
        ASRAM_WSET  = 3'b011,
        ASRAM_WR    = 3'b100,
        ASRAM_WEND  = 3'b101,
        ASRAM_TURN  = 3'b110
    } asram_state_t;
endpackage : asram_pkg

// >>> asram_timer.sv
// Down counter that times one controller phase (read, select-ahead, strobe or turnaround)
`timescale 1ns/100ps
`default_nettype none
module asram_timer
    import asram_pkg::*;
#(
    parameter int W = ASRAM_CNT_W
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         load,
    input  wire logic [W-1:0] loadVal,
    output logic              done
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } asram_tmr_t;

    asram_tmr_t cur_ff;
    asram_tmr_t nxt_cur;

    always_comb begin
        nxt_cur = cur_ff;
        if (load) begin
            nxt_cur.cnt = loadVal;
        end else if (cur_ff.cnt != '0) begin
            nxt_cur.cnt = cur_ff.cnt - W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Done must not depend on load: callers load when done, which would loop
    assign done = (cur_ff.cnt == '0);
endmodule : asram_timer
`default_nettype wire

// >>> asram_host.sv
// Host controller driving a 32K x 8 asynchronous static memory
`timescale 1ns/100ps
`default_nettype none
module asram_host
    import asram_pkg::*;
#(
    parameter int AW      = ASRAM_ADDR_W,
    parameter int DW      = ASRAM_DATA_W,
    // Timer width and phase lengths in clock cycles; retune the lengths for a different clock
    parameter int CW      = ASRAM_CNT_W,
    parameter int SET_CYC = ASRAM_SET_CYC,
    parameter int RD_CYC  = ASRAM_RD_CYC,
    parameter int WR_CYC  = ASRAM_WR_CYC,
    parameter int OFF_CYC = ASRAM_OFF_CYC
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    // User request side
    input  wire logic          reqValid,
    input  wire logic          reqWrite,
    input  wire logic [AW-1:0] reqAddr,
    input  wire logic [DW-1:0] reqWdata,
    output logic               reqReady,
    output logic               rdValid,
    output logic [DW-1:0]      rdData,
    // Memory pins
    output logic [AW-1:0]      wordSelectLines,
    output logic               chipSel_b,
    output logic               writeStrobe_b,
    output logic               outputDrive_b,
    input  wire logic [DW-1:0] dataIn,
    output logic [DW-1:0]      dataOut,
    output logic               dataOe
);
    typedef struct packed {
        asram_state_t  state;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic [DW-1:0] rdata;
        logic          rdValid;
        logic          ready;
        logic          cs_b;
        logic          we_b;
        logic          oe_b;
        logic          dOe;
    } asram_host_t;

    asram_host_t cur_ff;
    asram_host_t nxt_cur;

    logic          tmrLoad;
    logic [CW-1:0] tmrVal;
    logic          tmrDone;
    logic          takeReq;
    logic          takeRd;
    logic          takeWr;

    // Read and strobe phases load n-1, as the load edge itself counts;
    // select-ahead and turnaround load n, keeping one spare cycle of margin
    localparam logic [CW-1:0] SET_LOAD = CW'(SET_CYC);
    localparam logic [CW-1:0] RD_LOAD  = CW'(RD_CYC - 1);
    localparam logic [CW-1:0] WR_LOAD  = CW'(WR_CYC - 1);
    localparam logic [CW-1:0] OFF_LOAD = CW'(OFF_CYC);

    asram_timer #(
        .W       (CW)
    ) u_timer (
        .clk     (clk),
        .rst_b   (rst_b),
        .load    (tmrLoad),
        .loadVal (tmrVal),
        .done    (tmrDone)
    );

    // Ready is high only in idle, so a take can only start from there
    assign takeReq = reqValid && cur_ff.ready;
    assign takeRd  = takeReq && !reqWrite;
    assign takeWr  = takeReq && reqWrite;

    // Timer loads follow the phase being entered
    always_comb begin
        tmrLoad = 1'b0;
        tmrVal  = '0;
        case (cur_ff.state)
            ASRAM_IDLE: begin
                tmrLoad = takeReq;
                tmrVal  = takeWr ? SET_LOAD : RD_LOAD;
            end
            ASRAM_RDONE: begin
                tmrLoad = 1'b1;
                tmrVal  = OFF_LOAD;
            end
            ASRAM_WSET: begin
                // Safe only because the timer's done ignores its load input
                tmrLoad = tmrDone;
                tmrVal  = WR_LOAD;
            end
            default: begin
                tmrLoad = 1'b0;
                tmrVal  = '0;
            end
        endcase
    end

    always_comb begin
        nxt_cur         = cur_ff;
        nxt_cur.rdValid = 1'b0;
        case (cur_ff.state)
            ASRAM_IDLE: begin
                nxt_cur.cs_b  = 1'b1;
                nxt_cur.we_b  = 1'b1;
                nxt_cur.oe_b  = 1'b1;
                nxt_cur.dOe   = 1'b0;
                nxt_cur.ready = 1'b1;
                if (takeReq) begin
                    nxt_cur.ready = 1'b0;
                    nxt_cur.addr  = reqAddr;
                    nxt_cur.wdata = reqWdata;
                    nxt_cur.cs_b  = 1'b0;
                end
                if (takeWr) begin
                    // Select first with strobes high; memory stays released
                    nxt_cur.state = ASRAM_WSET;
                end
                if (takeRd) begin
                    nxt_cur.oe_b  = 1'b0;
                    nxt_cur.state = ASRAM_RD;
                end
            end
            ASRAM_RD: begin
                // Sample only after the full address/select access time
                if (tmrDone) begin
                    nxt_cur.rdata   = dataIn;
                    nxt_cur.rdValid = 1'b1;
                    nxt_cur.oe_b    = 1'b1;
                    nxt_cur.cs_b    = 1'b1;
                    nxt_cur.state   = ASRAM_RDONE;
                end
            end
            ASRAM_RDONE: begin
                // Let the memory release the bus before anything else
                nxt_cur.state = ASRAM_TURN;
            end
            ASRAM_WSET: begin
                if (tmrDone) begin
                    nxt_cur.we_b  = 1'b0;
                    nxt_cur.dOe   = 1'b1;
                    nxt_cur.state = ASRAM_WR;
                end
            end
            ASRAM_WR: begin
                if (tmrDone) begin
                    // Strobe ends the write; select and data held past it
                    nxt_cur.we_b  = 1'b1;
                    nxt_cur.state = ASRAM_WEND;
                end
            end
            ASRAM_WEND: begin
                // Data and address hold one cycle beyond the write-ending edge
                nxt_cur.cs_b  = 1'b1;
                nxt_cur.dOe   = 1'b0;
                nxt_cur.state = ASRAM_IDLE;
            end
            ASRAM_TURN: begin
                if (tmrDone) begin
                    nxt_cur.state = ASRAM_IDLE;
                end
            end
            default: begin
                nxt_cur.state = ASRAM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // Pins park at their inactive levels while in reset
            cur_ff.state   <= ASRAM_IDLE;
            cur_ff.addr    <= '0;
            cur_ff.wdata   <= '0;
            cur_ff.rdata   <= '0;
            cur_ff.rdValid <= 1'b0;
            cur_ff.ready   <= 1'b0;
            cur_ff.cs_b    <= 1'b1;
            cur_ff.we_b    <= 1'b1;
            cur_ff.oe_b    <= 1'b1;
            cur_ff.dOe     <= 1'b0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Pins come straight from flops, so the memory never sees a glitch
    assign reqReady        = cur_ff.ready;
    assign rdValid         = cur_ff.rdValid;
    assign rdData          = cur_ff.rdata;
    assign wordSelectLines = cur_ff.addr;
    assign chipSel_b       = cur_ff.cs_b;
    assign writeStrobe_b   = cur_ff.we_b;
    assign outputDrive_b   = cur_ff.oe_b;
    assign dataOut         = cur_ff.wdata;
    assign dataOe          = cur_ff.dOe;
endmodule : asram_host
`default_nettype wire

// >>> asram_mem_model.sv
// Behavioural 32K x 8 static memory seen from the host pins
`timescale 1ns/100ps
`default_nettype none
module asram_mem_model
    import asram_pkg::*;
(
    input  wire logic [14:0] wordSelectLines,
    input  wire logic        chipSel_b,
    input  wire logic        writeStrobe_b,
    input  wire logic        outputDrive_b,
    input  wire logic [7:0]  dataOut,
    input  wire logic        dataOe,
    output logic      [7:0]  dataIn
);
    logic [7:0] mem [0:32767];
    logic [7:0] last = 8'h00;
    logic       rdOn;
    logic       wrWin;
    assign rdOn  = !chipSel_b && writeStrobe_b && !outputDrive_b;
    assign wrWin = !chipSel_b && !writeStrobe_b;
    // Store what the wire shows when the overlap closes
    always @(negedge wrWin) mem[wordSelectLines] = dataOe ? dataOut : ~last;
    always @(negedge rdOn) last = mem[wordSelectLines];
    always @(negedge dataOe) last = dataOut;
    // Data shows only after the slowest access; released lines show the inverse
    assign #(ASRAM_ADDR_ACCESS_NS) dataIn = dataOe ? dataOut
        : (rdOn ? mem[wordSelectLines] : ~last);
endmodule : asram_mem_model
`default_nettype wire

// >>> asram_host_assertions.sv
// Pin timing and ordering checks for the host controller
`timescale 1ns/100ps
`default_nettype none
module asram_host_assertions (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        reqValid,
    input wire logic        reqWrite,
    input wire logic        reqReady,
    input wire logic [14:0] reqAddr,
    input wire logic [7:0]  reqWdata,
    input wire logic        rdValid,
    input wire logic [14:0] wordSelectLines,
    input wire logic        chipSel_b,
    input wire logic        writeStrobe_b,
    input wire logic        outputDrive_b,
    input wire logic [7:0]  dataOut,
    input wire logic        dataOe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_strobe; !writeStrobe_b [*2] ##1 writeStrobe_b; endsequence
    sequence s_rdSel; !chipSel_b && !outputDrive_b && writeStrobe_b; endsequence
    a_read_quiet: assert property (!outputDrive_b |-> writeStrobe_b && !dataOe)
        else $error("drive or strobe during read");
    a_window_sel: assert property (!writeStrobe_b |-> !chipSel_b && dataOe && $stable(wordSelectLines))
        else $error("write window malformed");
    a_deselect_idle: assert property (chipSel_b |-> writeStrobe_b && outputDrive_b)
        else $error("strobe active while deselected");
    a_strobe_width: assert property ($fell(writeStrobe_b) |-> s_strobe)
        else $error("write strobe width");
    a_end_setup: assert property ($rose(writeStrobe_b) |-> dataOe && $stable(dataOut) && $past(dataOe, 2))
        else $error("data setup or hold");
    a_end_select: assert property ($rose(writeStrobe_b) |-> !chipSel_b && !$past(chipSel_b, 2)
        && wordSelectLines == $past(wordSelectLines, 2))
        else $error("select or address setup");
    a_read_issue: assert property (reqValid && reqReady && !reqWrite |=> (s_rdSel
        and wordSelectLines == $past(reqAddr)) ##[1:2] rdValid)
        else $error("read cycle");
    a_write_issue: assert property (reqValid && reqReady && reqWrite |=> !chipSel_b
        && writeStrobe_b && dataOut == $past(reqWdata) && wordSelectLines == $past(reqAddr)
        ##[1:2] !writeStrobe_b)
        else $error("write cycle");
    a_turn_gap: assert property ($rose(outputDrive_b) |-> !dataOe [*3])
        else $error("host drives data too soon after a read");
endmodule : asram_host_assertions
bind asram_host asram_host_assertions i_chk (.clk(clk), .rst_b(rst_b), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqReady(reqReady), .reqAddr(reqAddr), .reqWdata(reqWdata),
    .rdValid(rdValid), .wordSelectLines(wordSelectLines), .chipSel_b(chipSel_b),
    .writeStrobe_b(writeStrobe_b), .outputDrive_b(outputDrive_b), .dataOut(dataOut), .dataOe(dataOe));
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench: host controller against the behavioural memory
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import asram_pkg::*;
();
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        reqValid = 1'b0;
    logic        reqWrite = 1'b0;
    logic [14:0] reqAddr = 15'h0000;
    logic [7:0]  reqWdata = 8'h00;
    logic        reqReady, rdValid, chipSel_b, writeStrobe_b, outputDrive_b, dataOe;
    logic [7:0]  rdData, dataIn, dataOut;
    logic [14:0] wordSelectLines, aq [$];
    logic [7:0]  shadow [int], expQ [$];
    logic [31:0] rnd = 32'h00005e38;
    int          fails = 0;
    int          n_tests = 0;
    always #(ASRAM_CLK_PERIOD_NS / 2) clk = ~clk;
    asram_host i_dut (.clk(clk), .rst_b(rst_b), .reqValid(reqValid), .reqWrite(reqWrite),
        .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady), .rdValid(rdValid),
        .rdData(rdData), .wordSelectLines(wordSelectLines), .chipSel_b(chipSel_b),
        .writeStrobe_b(writeStrobe_b), .outputDrive_b(outputDrive_b), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe));
    asram_mem_model i_mem (.wordSelectLines(wordSelectLines), .chipSel_b(chipSel_b),
        .writeStrobe_b(writeStrobe_b), .outputDrive_b(outputDrive_b), .dataOut(dataOut),
        .dataOe(dataOe), .dataIn(dataIn));
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    // Offered only once ready is seen, so no request is lost
    task automatic req(input logic w, input logic [14:0] a, input logic [7:0] d);
        int k;
        for (k = 0; k < 20 && reqReady !== 1'b1; k++) @(negedge clk);
        if (k == 20) begin
            fails++;
            summarize();
        end
        {reqValid, reqWrite, reqAddr, reqWdata} = {1'b1, w, a, d};
        if (w) shadow[a] = d;
        else expQ.push_back(shadow[a]);
        @(negedge clk);
        reqValid = 1'b0;
    endtask : req
    always @(negedge clk) begin
        if (rdValid === 1'b1) begin
            if (expQ.size() == 0) fails++;
            else cmp("rdData", expQ.pop_front(), rdData);
        end
    end
    initial begin
        repeat (4) @(negedge clk);
        cmp("idle pins", 8'h07, {5'h00, chipSel_b, writeStrobe_b, outputDrive_b});
        cmp("dataOe", 8'h00, {7'h00, dataOe});
        rst_b = 1'b1;
        $display("test reset done");
        aq = '{15'h0000, 15'h7fff};
        req(1'b1, 15'h0000, 8'ha5);
        req(1'b1, 15'h7fff, 8'h5a);
        for (int i = 0; i < 24; i++) begin
            rnd = rnd ^ (rnd << 13);
            rnd = rnd ^ (rnd >> 17);
            rnd = rnd ^ (rnd << 5);
            aq.push_back(rnd[14:0]);
            req(1'b1, rnd[14:0], rnd[22:15]);
        end
        foreach (aq[i]) req(1'b0, aq[i], 8'h00);
        $display("test write read done");
        // A write offered while busy must leave the byte untouched
        req(1'b1, 15'h0000, 8'h3c);
        @(negedge clk);
        cmp("reqReady", 8'h00, {7'h00, reqReady});
        {reqValid, reqWrite, reqWdata} = {1'b1, 1'b1, 8'hff};
        @(negedge clk);
        reqValid = 1'b0;
        req(1'b0, 15'h0000, 8'h00);
        for (int k = 0; k < 20 && expQ.size() > 0; k++) @(negedge clk);
        if (expQ.size() > 0) fails++;
        $display("test refuse done");
        summarize();
    end
endmodule : tb_top
`default_nettype wire
